// >>> position_latch_probes.sv
// Top of the two-channel position latch: function word, triggers, captures.
`timescale 1ns/1ns
`default_nettype none

module position_latch_probes
   import position_latch_pkg::*;
(
   input  wire logic              MCLK,                      // 20 MHz clock
   input  wire logic              RST,                       // Async reset
   input  wire logic              FUNC_WR,                   // Function write
   input  wire logic [WORD_W-1:0] FUNC_WDATA,                // Function data
   input  wire logic [POS_W-1:0]  FEEDBACK_POS,              // Motor position
   input  wire logic              EXTERNAL_PROBE_INPUT_ONE,  // Probe pin 1
   input  wire logic              EXTERNAL_PROBE_INPUT_TWO,  // Probe pin 2
   input  wire logic              ENCODER_ZERO,              // Index pulse
   input  wire logic [SET_W-1:0]  PROBE_FILTER_TIME_SETTING, // 10 ns units
   input  wire logic [1:0]        PROBE_POLARITY_SETTING,    // 1: invert
   output var  logic [WORD_W-1:0] FUNC_WORD,                 // Readback
   output var  logic [WORD_W-1:0] STATUS_WORD,               // Status
   output var  logic [POS_W-1:0]  PROBE1_RISE_POSITION,      // Ch1 rising
   output var  logic [POS_W-1:0]  PROBE1_FALL_POSITION,      // Ch1 falling
   output var  logic [POS_W-1:0]  PROBE2_RISE_POSITION,      // Ch2 rising
   output var  logic [POS_W-1:0]  PROBE2_FALL_POSITION       // Ch2 falling
);

   // ***************************************************************
   // Declarations
   // ***************************************************************
   logic [WORD_W-1:0]     func_q;        // Function word as written
   logic [WORD_W-1:0]     func_d;
   logic [SET_W-1:0]      set_clamped;   // Filter setting, at most 1000
   logic [15:0]           filt_ns;       // Filter time in ns
   logic [15:0]           filt_cyc_wide; // Filter time in cycles, rounded up
   logic [FILT_CNT_W-1:0] filt_cycles;   // Same, at counter width
   logic [NUM_CH-1:0]     probe_raw;     // Probe pins per channel
   logic [NUM_CH-1:0]     probe_filt;    // Filtered probe levels
   logic [1:0]            polarity;      // Inversion caught at restart

   // ***************************************************************
   // Function word
   // ***************************************************************
   // Stored exactly as written; the unused bits are the host's to keep
   // clear, and since no lane logic reads them a stray one is harmless.
   always_comb begin
      func_d = func_q;
      if (FUNC_WR) begin
         func_d = FUNC_WDATA;
      end
   end

   // Function word register, zero from reset
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         func_q <= FUNC_RESET;
      end else begin
         func_q <= func_d;
      end
   end

   // Readback comes from the flop itself
   assign FUNC_WORD = func_q;

   // ***************************************************************
   // Filter time conversion
   // ***************************************************************
   // The setting is a least stable time, so cycles round up. Values
   // beyond the documented range are clamped rather than wrapped.
   always_comb begin
      set_clamped   = (PROBE_FILTER_TIME_SETTING > FILT_SET_MAX) ?
                      FILT_SET_MAX : PROBE_FILTER_TIME_SETTING;
      filt_ns       = 16'(set_clamped * FILT_UNIT_NS);
      filt_cyc_wide = 16'((filt_ns + 16'(CLK_PERIOD_NS - 1)) / 16'(CLK_PERIOD_NS));
      filt_cycles   = filt_cyc_wide[FILT_CNT_W-1:0];
   end

   // ***************************************************************
   // Probe conditioning
   // ***************************************************************
   assign probe_raw = {EXTERNAL_PROBE_INPUT_TWO, EXTERNAL_PROBE_INPUT_ONE};

   // Polarity is taken only once after restart
   restart_strap u_polarity (
      .clk     (MCLK),
      .rst     (RST),
      .setting (PROBE_POLARITY_SETTING),
      .held    (polarity)
   );

   // ***************************************************************
   // Capture channels
   // ***************************************************************
   // Both lanes are identical copies of one block and share nothing but
   // the position input, the filter time and the encoder zero pulse, so both may be
   // armed and capture in the very same cycle.
   for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch

      lane_ctrl_t       ctrl;        // This lane of the function word
      lane_stat_t       stat_q;      // This lane of the status word
      lane_stat_t       stat_d;
      logic             armed_q;     // Enable as seen last cycle
      logic             armed_d;
      logic             active;      // Probe level, polarity applied
      logic             trig;        // Selected trigger level
      logic             trig_q;      // Trigger level last cycle
      logic             trig_d;
      logic             rise_evt;    // Rising edge of the trigger
      logic             fall_evt;    // Falling edge of the trigger
      logic             take_rise;   // Capture rising this cycle
      logic             take_fall;   // Capture falling this cycle
      logic             rise_st_q;   // Rising capture stored
      logic             rise_st_d;
      logic             fall_st_q;   // Falling capture stored
      logic             fall_st_d;
      logic [1:0]       cnt_q;       // Continuous capture count
      logic [1:0]       cnt_d;
      logic [POS_W-1:0] rise_pos_q;  // Rising capture position
      logic [POS_W-1:0] rise_pos_d;
      logic [POS_W-1:0] fall_pos_q;  // Falling capture position
      logic [POS_W-1:0] fall_pos_d;

      // Each lane reads its own byte of the function word
      assign ctrl = lane_ctrl_t'(func_q[ch*LANE_W +: LANE_W]);

      // Glitch filter on this lane's probe pin
      probe_filter u_filter (
         .clk   (MCLK),
         .rst   (RST),
         .raw   (probe_raw[ch]),
         .limit (filt_cycles),
         .filt  (probe_filt[ch])
      );

      // Trigger source and edge detection
      // Without inversion the probe is active low, so the pin level is
      // flipped; with inversion set it is taken as active high.
      always_comb begin
         active   = polarity[ch] ? probe_filt[ch] : ~probe_filt[ch];
         // Source select: encoder zero pulse or this lane's probe
         trig     = ctrl.src_zero ? ENCODER_ZERO : active;
         trig_d   = trig;
         rise_evt = trig & ~trig_q;
         fall_evt = ~trig & trig_q;
      end

      // Trigger history runs always, so enabling sees no false edge
      always_ff @(posedge MCLK or posedge RST) begin
         if (RST) begin
            trig_q <= 1'b0;
         end else begin
            trig_q <= trig_d;
         end
      end

      // Capture decision and next state
      // A capture needs the lane enabled now and already a cycle ago, so
      // the clear made on enabling never meets a capture in one cycle.
      always_comb begin
         armed_d    = ctrl.enable;
         rise_st_d  = rise_st_q;
         fall_st_d  = fall_st_q;
         cnt_d      = cnt_q;
         rise_pos_d = rise_pos_q;
         fall_pos_d = fall_pos_q;
         // Single mode: a stored edge blocks further captures of that edge
         take_rise  = ctrl.enable & armed_q & ctrl.rise_en & rise_evt &
                      (ctrl.continuous | ~rise_st_q);
         take_fall  = ctrl.enable & armed_q & ctrl.fall_en & fall_evt &
                      (ctrl.continuous | ~fall_st_q);
         if (ctrl.enable & ~armed_q) begin
            // Fresh enable: forget earlier captures and restart count
            rise_st_d = 1'b0;
            fall_st_d = 1'b0;
            cnt_d     = '0;
         end
         if (take_rise) begin
            // Position and flag move together on this edge
            rise_pos_d = FEEDBACK_POS;
            rise_st_d  = 1'b1;
         end
         if (take_fall) begin
            fall_pos_d = FEEDBACK_POS;
            fall_st_d  = 1'b1;
         end
         if (ctrl.continuous & (take_rise | take_fall)) begin
            // Two-bit counter wraps from 3 back to 0
            cnt_d = cnt_q + 2'b01;
         end
      end

      // Status lane built from next values, in step with the positions
      always_comb begin
         stat_d             = lane_stat_t'(LANE_RESET);
         stat_d.enabled     = ctrl.enable;
         stat_d.rise_stored = rise_st_d;
         stat_d.fall_stored = fall_st_d;
         stat_d.capture_cnt = cnt_d;
      end

      // Lane registers
      always_ff @(posedge MCLK or posedge RST) begin
         if (RST) begin
            armed_q    <= 1'b0;
            rise_st_q  <= 1'b0;
            fall_st_q  <= 1'b0;
            cnt_q      <= '0;
            rise_pos_q <= POS_RESET;
            fall_pos_q <= POS_RESET;
            stat_q     <= lane_stat_t'(LANE_RESET);
         end else begin
            armed_q    <= armed_d;
            rise_st_q  <= rise_st_d;
            fall_st_q  <= fall_st_d;
            cnt_q      <= cnt_d;
            rise_pos_q <= rise_pos_d;
            fall_pos_q <= fall_pos_d;
            stat_q     <= stat_d;
         end
      end
   end

   // ***************************************************************
   // Output assembly
   // ***************************************************************
   // Lane one fills the upper status byte, mirroring lane zero
   assign STATUS_WORD          = {g_ch[1].stat_q, g_ch[0].stat_q};
   // Each lane's own pair of position registers
   assign PROBE1_RISE_POSITION = g_ch[0].rise_pos_q;
   assign PROBE1_FALL_POSITION = g_ch[0].fall_pos_q;
   assign PROBE2_RISE_POSITION = g_ch[1].rise_pos_q;
   assign PROBE2_FALL_POSITION = g_ch[1].fall_pos_q;

endmodule

`default_nettype wire

// >>> position_latch_pkg.sv
// Constants, field layouts and carrier types for the two-channel position latch.
`default_nettype none

package position_latch_pkg;

   // ***************************************************************
   // Object indexes of the process image
   // ***************************************************************
   localparam logic [15:0] IDX_FUNCTION_WORD = 16'h60B8; // Function word
   localparam logic [15:0] IDX_STATUS_WORD   = 16'h60B9; // Status word
   localparam logic [15:0] IDX_RISE1_POS     = 16'h60BA; // Channel one rise
   localparam logic [15:0] IDX_FALL1_POS     = 16'h60BB; // Channel one fall
   localparam logic [15:0] IDX_RISE2_POS     = 16'h60BC; // Channel two rise
   localparam logic [15:0] IDX_FALL2_POS     = 16'h60BD; // Channel two fall

   // ***************************************************************
   // Widths and reset values
   // ***************************************************************
   localparam int          NUM_CH      = 2;         // Capture channels
   localparam int          LANE_W      = 8;         // Bits per channel lane
   localparam int          WORD_W      = 16;        // Function/status width
   localparam int          POS_W       = 32;        // Position width
   localparam int          FILT_CNT_W  = 8;         // Filter counter width
   localparam int          SET_W       = 10;        // Filter setting width
   localparam logic [15:0] FUNC_RESET  = 16'h0000;  // Function word reset
   localparam logic [7:0]  LANE_RESET  = 8'h00;     // Status lane reset
   localparam logic [31:0] POS_RESET   = 32'h0000_0000; // Position reset
   localparam logic [1:0]  POL_RESET   = 2'h0;      // Polarity before strap

   // ***************************************************************
   // Filter timing
   // ***************************************************************
   localparam int          CLK_PERIOD_NS   = 50;    // 20 MHz control clock
   localparam int          FILT_UNIT_NS    = 10;    // Filter setting unit
   localparam logic [9:0]  FILT_SET_MAX    = 10'h3E8; // 1000 units ceiling

   // ***************************************************************
   // Carriers: one lane of the function word and of the status word
   // ***************************************************************
   typedef struct packed {
      logic [1:0] unused_hi;   // Host keeps zero
      logic       fall_en;     // Capture on falling edge
      logic       rise_en;     // Capture on rising edge
      logic       unused_lo;   // Host keeps zero
      logic       src_zero;    // 1: encoder zero pulse, 0: external probe
      logic       continuous;  // 1: every event, 0: first event of each edge only
      logic       enable;      // Channel armed
   } lane_ctrl_t;

   typedef struct packed {
      logic [1:0] capture_cnt; // Continuous captures, wraps 0..3
      logic [2:0] reserved;    // Reads zero
      logic       fall_stored; // Falling capture held
      logic       rise_stored; // Rising capture held
      logic       enabled;     // Channel armed
   } lane_stat_t;

endpackage

`default_nettype wire

// >>> probe_filter.sv
// Digital glitch filter for one external probe input.
`timescale 1ns/1ns
`default_nettype none

module probe_filter
   import position_latch_pkg::*;
(
   input  wire logic                  clk,      // Control clock
   input  wire logic                  rst,      // Async reset, active high
   input  wire logic                  raw,      // Unfiltered pin level
   input  wire logic [FILT_CNT_W-1:0] limit,    // Stable cycles required
   output var  logic                  filt      // Filtered level
);

   logic                  filt_q;  // Accepted level
   logic                  filt_d;
   logic [FILT_CNT_W-1:0] cnt_q;   // Cycles the new level has held
   logic [FILT_CNT_W-1:0] cnt_d;

   // ***************************************************************
   // Next state
   // ***************************************************************
   // A new level is accepted only after it has held for limit cycles;
   // a limit of zero passes the pin with a single cycle of delay.
   always_comb begin
      filt_d = filt_q;
      cnt_d  = '0;
      if (raw != filt_q) begin
         // Limit is read live, so a new setting applies at once
         if (cnt_q >= limit) begin
            filt_d = raw;
         end else begin
            cnt_d = cnt_q + 1'b1;
         end
      end
   end

   // Registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         filt_q <= 1'b0;
         cnt_q  <= '0;
      end else begin
         filt_q <= filt_d;
         cnt_q  <= cnt_d;
      end
   end

   assign filt = filt_q;

endmodule

`default_nettype wire

// >>> restart_strap.sv
// Catches a setting once after reset release and holds it until restart.
`timescale 1ns/1ns
`default_nettype none

module restart_strap
   import position_latch_pkg::*;
(
   input  wire logic       clk,      // Control clock
   input  wire logic       rst,      // Async reset, active high
   input  wire logic [1:0] setting,  // Live setting level
   output var  logic [1:0] held      // Value taken at restart
);

   logic       taken_q;  // Setting already caught
   logic       taken_d;
   logic [1:0] held_q;   // Caught value
   logic [1:0] held_d;

   // ***************************************************************
   // Capture once
   // ***************************************************************
   // The reset itself loads a constant; the live level is sampled by
   // the first clock after release, so later changes need a restart.
   always_comb begin
      taken_d = 1'b1;
      held_d  = taken_q ? held_q : setting;
   end

   // Registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         taken_q <= 1'b0;
         held_q  <= POL_RESET;
      end else begin
         taken_q <= taken_d;
         held_q  <= held_d;
      end
   end

   assign held = held_q;

endmodule

`default_nettype wire

// >>> position_latch_probes_sva.sv
// Port-level checker for the two-channel position latch.
`timescale 1ns/1ns
`default_nettype none

module position_latch_probes_sva
   import position_latch_pkg::*;
(
   input wire logic              MCLK,                 // Control clock
   input wire logic              RST,                  // Async reset
   input wire logic              FUNC_WR,              // Function write
   input wire logic [WORD_W-1:0] FUNC_WDATA,           // Function data
   input wire logic [WORD_W-1:0] FUNC_WORD,            // Readback
   input wire logic [WORD_W-1:0] STATUS_WORD,          // Status
   input wire logic [POS_W-1:0]  PROBE1_RISE_POSITION, // Ch1 rising
   input wire logic [POS_W-1:0]  PROBE1_FALL_POSITION, // Ch1 falling
   input wire logic [POS_W-1:0]  PROBE2_RISE_POSITION, // Ch2 rising
   input wire logic [POS_W-1:0]  PROBE2_FALL_POSITION  // Ch2 falling
);
   // ***************************************************************
   // Properties, all in the control clock domain
   // ***************************************************************
   default clocking dflt @(posedge MCLK); endclocking
   default disable iff (RST);

   func_echo_a: assert property (FUNC_WR |=> FUNC_WORD == $past(FUNC_WDATA))
      else $error("function word readback wrong");
   // The status lane is built from the stored word, so it trails the readback by one cycle
   enable_stat_a: assert property (FUNC_WR |=> ##1 (STATUS_WORD & 16'h0101) ==
      ($past(FUNC_WDATA, 2) & 16'h0101)) else $error("enabled status wrong");
   rsvd_zero_a: assert property ((STATUS_WORD & 16'h3838) == 16'h0000)
      else $error("reserved status bits set");
   flag_pos_a: assert property ($changed(PROBE1_RISE_POSITION) |-> STATUS_WORD[1])
      else $error("rise position moved without flag");
   flag_pos2_a: assert property ($changed(PROBE2_FALL_POSITION) |-> STATUS_WORD[10])
      else $error("ch2 fall position moved without flag");
   off1_hold_a: assert property (!FUNC_WORD[0] |=> $stable(PROBE1_RISE_POSITION)
      && $stable(PROBE1_FALL_POSITION)) else $error("disabled ch1 captured");
   off2_hold_a: assert property (!FUNC_WORD[8] |=> $stable(PROBE2_RISE_POSITION)
      && $stable(PROBE2_FALL_POSITION)) else $error("disabled ch2 captured");
   rise1_off_a: assert property (!FUNC_WORD[4] |=> $stable(PROBE1_RISE_POSITION)
      && !$rose(STATUS_WORD[1])) else $error("ch1 rise captured while off");
   fall1_off_a: assert property (!FUNC_WORD[5] |=> $stable(PROBE1_FALL_POSITION)
      && !$rose(STATUS_WORD[2])) else $error("ch1 fall captured while off");
   rise2_off_a: assert property (!FUNC_WORD[12] |=> $stable(PROBE2_RISE_POSITION)
      && !$rose(STATUS_WORD[9])) else $error("ch2 rise captured while off");
   fall2_off_a: assert property (!FUNC_WORD[13] |=> $stable(PROBE2_FALL_POSITION)
      && !$rose(STATUS_WORD[10])) else $error("ch2 fall captured while off");
   single_lock_a: assert property (!FUNC_WORD[1] && STATUS_WORD[1] |=>
      $stable(PROBE1_RISE_POSITION)) else $error("single mode captured twice");
   count_step_a: assert property ($changed(STATUS_WORD[7:6]) |-> STATUS_WORD[7:6] ==
      $past(STATUS_WORD[7:6]) + 2'h1 || STATUS_WORD[7:6] == 2'h0)
      else $error("capture count jumped");
   // A fresh enable clears the count, so that cycle is left out
   count_hold_a: assert property (!FUNC_WORD[9] && !$rose(FUNC_WORD[8]) |=>
      $stable(STATUS_WORD[15:14])) else $error("ch2 counted in single mode");

   // Main scenarios reached
   cover property (FUNC_WR && FUNC_WDATA[1]);
   cover property ($rose(STATUS_WORD[1]) && STATUS_WORD[9]);
   cover property ($changed(STATUS_WORD[7:6]));
endmodule

bind position_latch_probes position_latch_probes_sva chk (
   .MCLK(MCLK), .RST(RST), .FUNC_WR(FUNC_WR), .FUNC_WDATA(FUNC_WDATA),
   .FUNC_WORD(FUNC_WORD), .STATUS_WORD(STATUS_WORD),
   .PROBE1_RISE_POSITION(PROBE1_RISE_POSITION), .PROBE1_FALL_POSITION(PROBE1_FALL_POSITION),
   .PROBE2_RISE_POSITION(PROBE2_RISE_POSITION), .PROBE2_FALL_POSITION(PROBE2_FALL_POSITION));

`default_nettype wire

// >>> host_model.sv
// Host motion controller model that writes the probe function word.
`timescale 1ns/1ns
`default_nettype none

module host_model
   import position_latch_pkg::*;
(
   input  wire logic              clk,   // Control clock
   output var  logic              wr,    // Write strobe
   output var  logic [WORD_W-1:0] wdata  // Function word data
);
   // Only defined function bits; the host keeps the unused ones zero
   localparam logic [15:0] LEGAL = 16'h3737;

   // Idle at time zero
   initial begin
      wr = 1'b0;
      wdata = 16'h0000;
   end

   // One-cycle write; afterwards the stale data is inverted, not left valid
   task automatic put(input logic [WORD_W-1:0] v);
      @(posedge clk);
      #1;
      wr = 1'b1;
      wdata = v & LEGAL;
      @(posedge clk);
      #1;
      wr = 1'b0;
      wdata = ~wdata;
   endtask
endmodule

`default_nettype wire

// >>> position_latch_probes_bench.sv
// Self-checking bench for the two-channel position latch.
`timescale 1ns/1ns
`default_nettype none

module position_latch_probes_bench;
   import position_latch_pkg::*;

   logic              mclk;        // 20 MHz clock
   logic              rst;         // Reset
   logic              pin1;        // Probe one, active high here
   logic              pin2;        // Probe two, active low here
   logic              zero;        // Encoder index
   logic [31:0]       pos;         // Feedback position
   logic [9:0]        filt;        // Filter setting
   logic [1:0]        pol;         // Polarity strap
   wire logic         wr;          // From host model
   wire logic [15:0]  wdata;       // From host model
   wire logic [15:0]  fw;          // Function readback
   wire logic [15:0]  st;          // Status word
   wire logic [31:0]  rp [2];      // Rise positions
   wire logic [31:0]  fp [2];      // Fall positions
   int                num_errors;  // Mismatches
   int                checked;     // Comparisons
   int                ch;          // Channel under test
   logic [31:0]       erp [2];     // Expected rise positions
   logic [31:0]       efp [2];     // Expected fall positions
   logic [31:0]       pv [4];      // Positions at each edge
   logic [7:0]        lane;        // Control lane
   logic              re, fe, md, z;
   logic [1:0]        cnt;         // Expected capture count

   position_latch_probes DUT (
      .MCLK(mclk), .RST(rst), .FUNC_WR(wr), .FUNC_WDATA(wdata), .FEEDBACK_POS(pos),
      .EXTERNAL_PROBE_INPUT_ONE(pin1), .EXTERNAL_PROBE_INPUT_TWO(pin2), .ENCODER_ZERO(zero),
      .PROBE_FILTER_TIME_SETTING(filt), .PROBE_POLARITY_SETTING(pol), .FUNC_WORD(fw),
      .STATUS_WORD(st), .PROBE1_RISE_POSITION(rp[0]), .PROBE1_FALL_POSITION(fp[0]),
      .PROBE2_RISE_POSITION(rp[1]), .PROBE2_FALL_POSITION(fp[1]));

   host_model host (.clk(mclk), .wr(wr), .wdata(wdata));

   // ***************************************************************
   // Helpers
   // ***************************************************************
   always #25 mclk = ~mclk;

   function automatic logic [7:0] lane_exp(input logic en, input logic r, input logic f,
                                           input logic [1:0] c);
      lane_exp = {c, 3'b000, f, r, en};
   endfunction

   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: expected %h, got %h", $time, exp, got);
      end
   endtask

   // Logical trigger level; position held 70 cycles, past the 50-cycle delay of the longest filter set here
   task automatic drv(input int c, input logic zs, input logic lvl, input logic [31:0] p);
      pos = p;
      if (zs) zero = lvl;
      else if (c == 0) pin1 = lvl;
      else pin2 = ~lvl;
      repeat (70) @(posedge mclk);
      #1;
   endtask

   task automatic wait3();
      repeat (3) @(posedge mclk);
      #1;
   endtask

   task automatic summarize();
      if (num_errors == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Cuts a hang short; the tests need about 190 us
   initial begin
      #1_000_000;
      num_errors++;
      summarize();
   end

   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial begin
      void'($urandom(18012));
      // Reset held, probe pins at their idle levels for the strap below
      {mclk, rst, pin1, pin2, zero} = 5'b01010;
      {pos, filt, pol} = {32'h0, 10'h0, 2'b01};
      {num_errors, checked} = 0;
      erp = '{32'h0, 32'h0};
      efp = '{32'h0, 32'h0};
      repeat (2) @(posedge mclk);
      #1;
      rst = 1'b0;
      repeat (10) @(posedge mclk);
      #1;
      chk(16'h0000, fw);
      chk(16'h0000, st);
      // Every channel, source and mode; the idle lane is armed on its probe
      for (int i = 0; i < 8; i++) begin
         ch = i % 2;
         z = (i / 2) % 2;
         md = i / 4;
         re = $urandom % 2;
         fe = $urandom % 2;
         filt = $urandom % 251;
         lane = {2'b00, fe, re, 1'b0, z, md, 1'b1};
         host.put(16'h0000);
         host.put(ch ? {lane, 8'h33} : {8'h33, lane});
         wait3();
         for (int k = 0; k < 4; k++) begin
            pv[k] = $urandom;
            drv(ch, z, k % 2 == 0, pv[k]);
         end
         if (re) erp[ch] = md ? pv[2] : pv[0];
         if (fe) efp[ch] = md ? pv[3] : pv[1];
         cnt = md ? 2'(2 * (re + fe)) : 2'h0;
         chk(lane_exp(1'b1, re, fe, cnt), ch ? st[15:8] : st[7:0]);
         chk(8'h01, ch ? st[7:0] : st[15:8]);
         chk(ch ? {lane, 8'h33} : {8'h33, lane}, fw);
         chk(erp[ch], rp[ch]);
         chk(efp[ch], fp[ch]);
         chk(erp[1 - ch], rp[1 - ch]);
         chk(efp[1 - ch], fp[1 - ch]);
         // Disabled: flags kept, no new captures
         host.put(16'h0000);
         drv(ch, z, 1'b1, $urandom);
         drv(ch, z, 1'b0, $urandom);
         chk(lane_exp(1'b0, re, fe, cnt), ch ? st[15:8] : st[7:0]);
         chk(efp[ch], fp[ch]);
      end
      // Short glitch: refused at 20 cycles of filter, taken with none
      for (int j = 0; j < 2; j++) begin
         filt = j ? 10'd0 : 10'd100;
         host.put(16'h0000);
         host.put(16'h0013);
         wait3();
         pin1 = 1'b1;
         repeat (5) @(posedge mclk);
         #1;
         pin1 = 1'b0;
         repeat (40) @(posedge mclk);
         #1;
         chk(j ? 8'h43 : 8'h01, st[7:0]);
      end
      // Both channels on the index pulse at once, continuous, both edges
      host.put(16'h0000);
      host.put(16'h3737);
      wait3();
      pv[0] = $urandom;
      drv(0, 1'b1, 1'b1, pv[0]);
      pv[1] = $urandom;
      drv(0, 1'b1, 1'b0, pv[1]);
      chk(16'h8787, st);
      chk(pv[0], rp[0]);
      chk(pv[0], rp[1]);
      chk(pv[1], fp[1]);
      chk(pv[1], fp[0]);
      // Restart mid-run with a random polarity strap; pins idle at the new sense
      pol  = $urandom;
      pin1 = ~pol[0];
      pin2 = ~pol[1];
      rst  = 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      rst = 1'b0;
      wait3();
      chk(32'h0, rp[0]);
      chk(16'h0000, fw);
      host.put(16'h1111);
      wait3();
      pv[0] = $urandom;
      pos   = pv[0];
      pin1  = pol[0];
      pin2  = pol[1];
      repeat (70) @(posedge mclk);
      #1;
      chk(16'h0303, st);
      chk(pv[0], rp[0]);
      chk(pv[0], rp[1]);
      summarize();
   end
endmodule

`default_nettype wire
